/* dv/hctig_host.sv */
// Host model: sends whole command packets and waits for the reply pulse
`timescale 1ns/100ps
`default_nettype none
module hctig_host (
    input  wire logic  CLK,
    input  wire logic  RSP_VALID,
    output logic [3:0] CMD_VALID,
    output logic [7:0] CMD_TYPE,
    output logic [7:0] CMD_LEN,
    output logic [7:0] CMD_DATA [0:21]
);
    logic got;
    initial begin
        CMD_VALID = 4'h0;
        CMD_TYPE = 8'h00;
        CMD_LEN = 8'h00;
        got = 1'b0;
        for (int i = 0; i < 22; i++) CMD_DATA[i] = 8'h00;
    end
    // Packet stands for the taking edge only, then type and data bytes 0-3 are inverted so stale bytes never help
    task automatic send(input logic [3:0] v, input logic [7:0] t, input logic [7:0] n,
                        input logic [31:0] d);
        @(negedge CLK);
        CMD_VALID = v;
        CMD_TYPE = t;
        CMD_LEN = n;
        for (int i = 0; i < 4; i++) CMD_DATA[i] = d[8*i +: 8];
        @(negedge CLK);
        CMD_VALID = 4'h0;
        CMD_TYPE = ~t;
        for (int i = 0; i < 4; i++) CMD_DATA[i] = ~d[8*i +: 8];
        got = 1'b0;
        // Reply is awaited for up to four cycles before any new packet, as a baud change demands
        for (int i = 0; i < 4 && !got; i++) begin
            if (RSP_VALID === 1'b1) begin
                got = 1'b1;
            end else begin
                @(negedge CLK);
            end
        end
    endtask
endmodule
`default_nettype wire

/* dv/tb_hctig_core.sv */
// Testbench for the command interpreter
`timescale 1ns/100ps
`default_nettype none
module tb_hctig_core;
    logic        CLK = 1'b0;
    logic        RESET_N = 1'b0;
    logic [20:0] PIN_IN = 21'h000000;
    logic [11:0] ADC0 = 12'habc;
    logic        RSP_VALID;
    logic [1:0]  RSP_IF;
    logic [7:0]  RSP_TYPE;
    logic [7:0]  RSP_LEN;
    logic [7:0]  RSP_DATA [0:19];
    logic [3:0]  CMD_VALID;
    logic [7:0]  CMD_TYPE;
    logic [7:0]  CMD_LEN;
    logic [7:0]  CMD_DATA [0:21];
    int          mismatches = 0;
    int          compares = 0;
    always #2.5 CLK = ~CLK;
    hctig_host u_hctig_host (.CLK(CLK), .RSP_VALID(RSP_VALID), .CMD_VALID(CMD_VALID),
        .CMD_TYPE(CMD_TYPE), .CMD_LEN(CMD_LEN), .CMD_DATA(CMD_DATA));
    // Short poll and sample periods keep the run brief
    hctig_core #(.POLL_CYC(8), .ADC_CYC(4), .PWM_STEP(1)) u_hctig_core (
        .CLK(CLK), .RESET_N(RESET_N), .CMD_VALID(CMD_VALID), .CMD_TYPE(CMD_TYPE),
        .CMD_LEN(CMD_LEN), .CMD_DATA(CMD_DATA), .STORE_BOOT(1'b0), .PIN_IN(PIN_IN),
        .ADC0(ADC0), .ADC1(12'h7ff), .CMD_READY(), .RSP_VALID(RSP_VALID), .RSP_IF(RSP_IF),
        .RSP_TYPE(RSP_TYPE), .RSP_LEN(RSP_LEN), .RSP_DATA(RSP_DATA), .BAUD_CODE(),
        .SPI_MODE(), .I2C_ADDR(), .I2C_FAST(), .IF_ENABLED(), .PIN_ERR_SEL(), .PIN_OUT(),
        .PIN_OE_N(), .BOOT_OPT(), .BOOT_BAUD());
    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rsp(input logic [7:0] t, input logic [7:0] n);
        chk("reply seen", 8'h01, {7'h00, u_hctig_host.got});
        chk("reply type", t, RSP_TYPE);
        chk("reply length", n, RSP_LEN);
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_text();
        u_hctig_host.send(4'h1, 8'h1f, 8'h04, 32'h42410112);
        rsp(8'h5f, 8'h00);
        u_hctig_host.send(4'h1, 8'h20, 8'h03, 32'h00020112);
        rsp(8'h60, 8'h02);
        chk("text 0", 8'h41, RSP_DATA[0]);
        chk("text 1", 8'h42, RSP_DATA[1]);
        u_hctig_host.send(4'h1, 8'h20, 8'h03, 32'h00010000);
        chk("blank cell", 8'h20, RSP_DATA[0]);
    endtask
    task automatic test_err();
        u_hctig_host.send(4'h1, 8'h1f, 8'h03, 32'h00410014);
        rsp(8'hdf, 8'h00);
        u_hctig_host.send(4'h1, 8'h20, 8'h03, 32'h00150000);
        rsp(8'he0, 8'h00);
        u_hctig_host.send(4'h1, 8'h20, 8'h04, 32'h00010000);
        rsp(8'he0, 8'h00);
    endtask
    task automatic test_opt();
        u_hctig_host.send(4'h1, 8'h21, 8'h01, 32'h00000000);
        rsp(8'h61, 8'h03);
        chk("serial index", 8'h00, RSP_DATA[0]);
        chk("serial flags", 8'h07, RSP_DATA[1]);
        u_hctig_host.send(4'h1, 8'h21, 8'h01, 32'h00000001);
        rsp(8'h61, 8'h02);
        chk("usb flags", 8'h01, RSP_DATA[1]);
    endtask
    task automatic test_multi();
        u_hctig_host.send(4'hc, 8'h20, 8'h03, 32'h00010000);
        rsp(8'h60, 8'h01);
        chk("reply port", 8'h02, {6'h00, RSP_IF});
    endtask
    task automatic pin_q(input logic [7:0] st);
        u_hctig_host.send(4'h1, 8'h22, 8'h01, 32'h00000001);
        rsp(8'h62, 8'h04);
        chk("pin status", st, RSP_DATA[1]);
    endtask
    task automatic test_pin();
        PIN_IN[1] = 1'b1;
        repeat (40) @(negedge CLK);
        pin_q(8'h05);
        pin_q(8'h01);
        PIN_IN[1] = 1'b0;
        repeat (40) @(negedge CLK);
        pin_q(8'h02);
    endtask
    task automatic test_adc();
        u_hctig_host.send(4'h1, 8'h22, 8'h01, 32'h0000000d);
        rsp(8'h62, 8'h07);
        chk("adc min hi", 8'h0a, RSP_DATA[4]);
        chk("adc max lo", 8'hbc, RSP_DATA[5]);
        ADC0 = 12'h123;
        repeat (20) @(negedge CLK);
        u_hctig_host.send(4'h1, 8'h22, 8'h01, 32'h0000000d);
        repeat (20) @(negedge CLK);
        u_hctig_host.send(4'h1, 8'h22, 8'h01, 32'h0000000d);
        chk("adc min lo", 8'h23, RSP_DATA[3]);
        chk("adc max hi", 8'h01, RSP_DATA[6]);
    endtask
    initial begin
        repeat (20) @(negedge CLK);
        RESET_N = 1'b1;
        test_text();
        test_err();
        test_opt();
        test_multi();
        test_pin();
        test_adc();
        test_done();
    end
    // Whole sequence needs about 170 cycles; cut a hang well beyond that
    initial begin
        #20000;
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire

/* rtl/hctig_core.sv */
// Command interpreter for text, interface options and pin sampling
// Functional notes
// - Text write 0x1F, length 3-22, col,row,chars
// - Reply type is command type with 0x40
// - Text read 0x20, three bytes, count 1-20
// - Read returns only text write characters; code returns spaces (0x20) for cells never written
// - Accept traffic on every enabled interface; code serves only the lowest valid one per cycle
// - Options live now, boot only if stored
// - Enabled interface owns its shared pins
// - Option bits: enable,interp,report,errlocal,errany
// - USB stays partly alive when disabled
// - Interpreter needs enable; replies to origin
// - Option read 0x21 echoes index and flags
// - SPI record four bytes, mode bits 0-2
// - I2C record: 7-bit address, speed 0-1
// - Baud change applies after acknowledge sent
// - Output pin drives level or 100 Hz PWM
// - Input pins sampled at 50 Hz
// - Rise/fall records cleared on host query
// - ADC 11 kHz, avg*16, min, max, reset; code sends the raw sample sum, low 16 bits
// - ADC values 12-bit unsigned
// - Pins of enabled interfaces ignore settings
// - Default pin setup suits power control
// - Pin status: state, fall, rise bits
`timescale 1ns/100ps
`default_nettype none
module hctig_core #(
    parameter int POLL_CYC = hctig_pkg::POLL_CYC,
    parameter int ADC_CYC  = hctig_pkg::ADC_CYC,
    parameter int PWM_STEP = hctig_pkg::PWM_STEP_CYC
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic [3:0]  CMD_VALID,
    input  wire logic [7:0]  CMD_TYPE,
    input  wire logic [7:0]  CMD_LEN,
    input  wire logic [7:0]  CMD_DATA [0:21],
    input  wire logic        STORE_BOOT,
    input  wire logic [20:0] PIN_IN,
    input  wire logic [11:0] ADC0,
    input  wire logic [11:0] ADC1,
    output logic             CMD_READY,
    output logic             RSP_VALID,
    output logic [1:0]       RSP_IF,
    output logic [7:0]       RSP_TYPE,
    output logic [7:0]       RSP_LEN,
    output logic [7:0]       RSP_DATA [0:19],
    output logic [2:0]       BAUD_CODE,
    output logic [7:0]       SPI_MODE,
    output logic [7:0]       I2C_ADDR,
    output logic             I2C_FAST,
    output logic [3:0]       IF_ENABLED,
    output logic [4:0]       PIN_ERR_SEL,
    output logic [20:0]      PIN_OUT,
    output logic [20:0]      PIN_OE_N,
    output logic [7:0]       BOOT_OPT [0:3],
    output logic [1:0]       BOOT_BAUD
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [79:0][7:0]  text;
        logic [3:0][7:0]   opt;
        logic [1:0]        baud;
        logic [1:0]        baud_pend;
        logic              baud_chg;
        logic [7:0]        spi;
        logic [7:0]        i2c_a;
        logic              i2c_s;
        logic [3:0][7:0]   boot_opt;
        logic [1:0]        boot_baud;
        logic [20:0][7:0]  duty;
        logic [20:0][7:0]  cfg;
        logic [31:0]       pwm_div;
        logic [6:0]        pwm_ph;
        logic [31:0]       poll_div;
        logic [31:0]       adc_div;
        logic [1:0][23:0]  acc;
        logic [1:0][15:0]  cnt;
        logic [1:0][11:0]  amin;
        logic [1:0][11:0]  amax;
        logic [20:0]       in_s1;
        logic [20:0]       in_s2;
        logic              rsp_v;
        logic [1:0]        rsp_if;
        logic [7:0]        rsp_t;
        logic [7:0]        rsp_l;
        logic [19:0][7:0]  rsp_d;
        logic [20:0]       pout;
        logic [20:0]       poe_n;
        logic [4:0]        perr;
    } hctig_st_t;
    hctig_st_t s_r, s_nxt;
    logic        tick_poll;
    logic        pin_query;
    logic [2:0]  pst [0:20];
    logic [4:0]  q_idx;
    // Interface owning a pin: serial 15,16; SPI 17-20; I2C 0,4
    function automatic logic owned(input logic [4:0] i, input logic [3:0][7:0] o);
        owned = ((i == 5'd15 || i == 5'd16) && o[0][hctig_pkg::OPT_EN]) ||
                (i >= 5'd17 && o[2][hctig_pkg::OPT_EN]) ||
                ((i == 5'd0 || i == 5'd4) && o[3][hctig_pkg::OPT_EN]);
    endfunction
    // ------------------------------------------------------------
    // Pin samplers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < hctig_pkg::NPIN; g++) begin : g_pin
            hctig_pin_if pif ();
            assign pif.tick  = tick_poll;
            assign pif.level = s_r.in_s2[g];
            assign pif.query = pin_query && (q_idx == 5'(g));
            assign pst[g]    = pif.status;
            hctig_pin_track u_trk (.CLK(CLK), .RESET_N(RESET_N), .p(pif));
        end
    endgenerate
    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic [1:0] src;
    logic       go;
    logic [7:0] d0, d1, d2, d3;
    logic [6:0] pos;
    logic [7:0] ln;
    logic       ok;
    always_comb begin
        src = 2'd0;
        for (int k = 3; k >= 0; k--) if (CMD_VALID[k]) src = 2'(k);
        // Interpreter honoured only when the interface is enabled, except on USB
        go  = CMD_VALID[src] && s_r.opt[src][hctig_pkg::OPT_INT] &&
              (s_r.opt[src][hctig_pkg::OPT_EN] || src == 2'd1);
        d0  = CMD_DATA[0];
        d1  = CMD_DATA[1];
        d2  = CMD_DATA[2];
        d3  = CMD_DATA[3];
        ln  = CMD_LEN;
        pos = 7'(d1 * hctig_pkg::COLS + d0);
        q_idx = d0[4:0];
        pin_query = 1'b0;
        tick_poll = (s_r.poll_div == 32'(POLL_CYC - 1));
        s_nxt = s_r;
        s_nxt.rsp_v = 1'b0;
        s_nxt.in_s1 = PIN_IN;
        s_nxt.in_s2 = s_r.in_s1;
        s_nxt.poll_div = tick_poll ? 32'd0 : s_r.poll_div + 32'd1;
        // PWM: 100 steps per 10 ms period
        if (s_r.pwm_div == 32'(PWM_STEP - 1)) begin
            s_nxt.pwm_div = 32'd0;
            s_nxt.pwm_ph  = (s_r.pwm_ph == 7'd99) ? 7'd0 : s_r.pwm_ph + 7'd1;
        end else begin
            s_nxt.pwm_div = s_r.pwm_div + 32'd1;
        end
        for (int i = 0; i < hctig_pkg::NPIN; i++) begin
            s_nxt.pout[i] = ({1'b0, s_r.pwm_ph} < s_r.duty[i]);
            s_nxt.poe_n[i] = (s_r.cfg[i][2:0] == 3'd2) || owned(5'(i), s_r.opt);
        end
        // ADC accumulate at 11 kHz
        if (s_r.adc_div == 32'(ADC_CYC - 1)) begin
            s_nxt.adc_div = 32'd0;
            for (int a = 0; a < 2; a++) begin
                logic [11:0] v;
                v = a == 0 ? ADC0 : ADC1;
                s_nxt.acc[a] = s_r.acc[a] + 24'(v);
                s_nxt.cnt[a] = s_r.cnt[a] + 16'd1;
                if (s_r.cnt[a] == 16'd0 || v < s_r.amin[a]) s_nxt.amin[a] = v;
                if (s_r.cnt[a] == 16'd0 || v > s_r.amax[a]) s_nxt.amax[a] = v;
            end
        end else begin
            s_nxt.adc_div = s_r.adc_div + 32'd1;
        end
        if (s_r.baud_chg) begin
            s_nxt.baud     = s_r.baud_pend;
            s_nxt.baud_chg = 1'b0;
        end
        if (STORE_BOOT) begin
            s_nxt.boot_opt  = s_r.opt;
            s_nxt.boot_baud = s_r.baud;
        end
        if (go) begin
            ok = 1'b1;
            s_nxt.rsp_v  = 1'b1;
            s_nxt.rsp_if = src;
            s_nxt.rsp_l  = 8'd0;
            s_nxt.rsp_d  = '0;
            unique case (CMD_TYPE)
                hctig_pkg::TYPE_TXT_WR: begin
                    ok = ln >= hctig_pkg::TXT_WR_MIN && ln <= hctig_pkg::TXT_WR_MAX &&
                         d0 < hctig_pkg::COLS && d1 < hctig_pkg::ROWS &&
                         {1'b0, d0} + 9'(ln) - 9'd3 <= 9'(hctig_pkg::COLS);
                    if (ok)
                        for (int c = 0; c < 20; c++)
                            if (8'(c) < ln - 8'd2) s_nxt.text[7'(pos + 7'(c))] = CMD_DATA[c+2];
                end
                hctig_pkg::TYPE_TXT_RD: begin
                    ok = ln == hctig_pkg::TXT_RD_LEN && d0 < hctig_pkg::COLS &&
                         d1 < hctig_pkg::ROWS && d2 != 8'd0 &&
                         {1'b0, d0} + {1'b0, d2} <= 9'(hctig_pkg::COLS);
                    if (ok) begin
                        s_nxt.rsp_l = d2;
                        for (int c = 0; c < 20; c++)
                            if (8'(c) < d2) s_nxt.rsp_d[c] = s_r.text[7'(pos + 7'(c))];
                    end
                end
                hctig_pkg::TYPE_IF_OPT: begin
                    if (ln == 8'd1) begin
                        ok = d0 <= hctig_pkg::IF_I2C;
                        s_nxt.rsp_d[0] = d0;
                        s_nxt.rsp_d[1] = s_r.opt[d0[1:0]];
                        unique case (d0[1:0])
                            2'd0: begin s_nxt.rsp_l = 8'd3; s_nxt.rsp_d[2] = {6'd0, s_r.baud}; end
                            2'd1: s_nxt.rsp_l = 8'd2;
                            2'd2: begin s_nxt.rsp_l = 8'd4; s_nxt.rsp_d[2] = s_r.spi; end
                            2'd3: begin
                                s_nxt.rsp_l = 8'd4;
                                s_nxt.rsp_d[2] = s_r.i2c_a;
                                s_nxt.rsp_d[3] = {7'd0, s_r.i2c_s};
                            end
                        endcase
                    end else begin
                        unique case (d0)
                            hctig_pkg::IF_SER: ok = ln == 8'd3 && d2 <= hctig_pkg::BAUD_MAX;
                            hctig_pkg::IF_USB: ok = ln == 8'd2;
                            hctig_pkg::IF_SPI: ok = ln == 8'd4 && (d2 & ~hctig_pkg::SPI_MASK) == 8'd0;
                            hctig_pkg::IF_I2C: ok = ln == 8'd4 && d2 <= hctig_pkg::I2C_AMAX &&
                                                    d3 <= hctig_pkg::I2C_SMAX;
                            default: ok = 1'b0;
                        endcase
                        if (ok) begin
                            // Interpreter bit dropped when interface disabled
                            s_nxt.opt[d0[1:0]] = {3'd0, d1[4:2],
                                d1[hctig_pkg::OPT_INT] & d1[hctig_pkg::OPT_EN], d1[0]};
                            if (d0 == hctig_pkg::IF_SER) begin
                                s_nxt.baud_pend = d2[1:0];
                                s_nxt.baud_chg  = 1'b1;
                            end
                            if (d0 == hctig_pkg::IF_SPI) s_nxt.spi = d2 & hctig_pkg::SPI_MASK;
                            if (d0 == hctig_pkg::IF_I2C) begin
                                s_nxt.i2c_a = d2;
                                s_nxt.i2c_s = d3[0];
                            end
                        end
                    end
                end
                hctig_pkg::TYPE_PIN: begin
                    ok = d0 <= hctig_pkg::PIN_MAX && ln >= 8'd1 && ln <= 8'd3;
                    if (ok && ln == 8'd1) begin
                        s_nxt.rsp_d[0] = d0;
                        if ((d0 == hctig_pkg::ADC0_IDX || d0 == hctig_pkg::ADC1_IDX) &&
                            !s_r.cfg[d0[4:0]][3]) begin
                            s_nxt.rsp_l = 8'd7;
                            s_nxt.rsp_d[1] = s_r.acc[d0[0] ? 0 : 1][7:0];
                            s_nxt.rsp_d[2] = s_r.acc[d0[0] ? 0 : 1][15:8];
                            s_nxt.rsp_d[3] = s_r.amin[d0[0] ? 0 : 1][7:0];
                            s_nxt.rsp_d[4] = {4'd0, s_r.amin[d0[0] ? 0 : 1][11:8]};
                            s_nxt.rsp_d[5] = s_r.amax[d0[0] ? 0 : 1][7:0];
                            s_nxt.rsp_d[6] = {4'd0, s_r.amax[d0[0] ? 0 : 1][11:8]};
                            s_nxt.acc[d0[0] ? 0 : 1] = '0;
                            s_nxt.cnt[d0[0] ? 0 : 1] = '0;
                        end else begin
                            pin_query = 1'b1;
                            s_nxt.rsp_l = 8'd4;
                            s_nxt.rsp_d[1] = {5'd0, pst[d0[4:0]]};
                            s_nxt.rsp_d[2] = s_r.duty[d0[4:0]];
                            s_nxt.rsp_d[3] = s_r.cfg[d0[4:0]];
                        end
                    end else if (ok) begin
                        ok = d1 <= hctig_pkg::DUTY_MAX &&
                             (ln == 8'd2 || ((d2 & hctig_pkg::CFG_RSVD) == 8'd0 &&
                              d2[2:0] != hctig_pkg::DRV_BAD[2:0]));
                        s_nxt.perr = d0[4:0];
                        if (ok && !owned(d0[4:0], s_r.opt)) begin
                            s_nxt.duty[d0[4:0]] = d1;
                            if (ln == 8'd3 && d0 < 8'd5) s_nxt.cfg[d0[4:0]] = d2;
                        end
                    end
                end
                default: ok = 1'b0;
            endcase
            s_nxt.rsp_t = ok ? (CMD_TYPE | hctig_pkg::REPLY_BIT)
                             : (CMD_TYPE | hctig_pkg::TYPE_ERR_BASE);
            if (!ok) s_nxt.rsp_l = 8'd0;
        end else begin
            ok = 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            s_r <= '0;
            s_r.text <= {80{8'h20}};
            // Element order is I2C, SPI, USB, serial
            s_r.opt  <= {hctig_pkg::OPT_RST, hctig_pkg::OPT_RST,
                         hctig_pkg::OPT_USB_F, hctig_pkg::OPT_RST};
            s_r.cfg  <= {21{hctig_pkg::CFG_DFLT}};
            s_r.poe_n <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign CMD_READY   = RESET_N;
    assign RSP_VALID   = s_r.rsp_v;
    assign RSP_IF      = s_r.rsp_if;
    assign RSP_TYPE    = s_r.rsp_t;
    assign RSP_LEN     = s_r.rsp_l;
    for (g = 0; g < 20; g++) begin : g_rd
        assign RSP_DATA[g] = s_r.rsp_d[g];
    end
    for (g = 0; g < 4; g++) begin : g_bo
        assign BOOT_OPT[g] = s_r.boot_opt[g];
        assign IF_ENABLED[g] = s_r.opt[g][hctig_pkg::OPT_EN];
    end
    assign BAUD_CODE   = {1'b0, s_r.baud};
    assign SPI_MODE    = s_r.spi;
    assign I2C_ADDR    = s_r.i2c_a;
    assign I2C_FAST    = s_r.i2c_s;
    assign PIN_ERR_SEL = s_r.perr;
    assign PIN_OUT     = s_r.pout;
    assign PIN_OE_N    = s_r.poe_n;
    assign BOOT_BAUD   = s_r.boot_baud;
    a_reply_type: assert property (@(posedge CLK) disable iff (!RESET_N)
        go && CMD_TYPE == hctig_pkg::TYPE_TXT_RD && ok |=> RSP_TYPE == 8'h60)
        else $error("text read reply type wrong");
    a_baud_after: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_r.baud_chg |=> s_r.baud == $past(s_r.baud_pend))
        else $error("baud not switched after acknowledge");
    a_owned_pin: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_r.opt[0][0] |=> PIN_OE_N[15] && PIN_OE_N[16])
        else $error("serial pins not released");
    a_err_reply: assert property (@(posedge CLK) disable iff (!RESET_N)
        go && !ok |=> RSP_LEN == 8'h00 && RSP_TYPE[7:6] == 2'b11)
        else $error("bad command not answered with error");
endmodule
`default_nettype wire

/* rtl/hctig_pin_if.sv */
// Interface carrying one pin's sampled level, query strobe and status
`timescale 1ns/100ps
`default_nettype none
interface hctig_pin_if;
    logic       tick;
    logic       level;
    logic       query;
    logic [2:0] status;
    modport core (output tick, output query, input status);
    modport pin  (input tick, input level, input query, output status);
endinterface
`default_nettype wire

/* rtl/hctig_pin_track.sv */
// One input pin sampler with edge records cleared on query
`timescale 1ns/100ps
`default_nettype none
module hctig_pin_track (
    input  wire logic    CLK,
    input  wire logic    RESET_N,
    hctig_pin_if.pin     p
);
    typedef struct packed {
        logic last;
        logic fall;
        logic rise;
    } hctig_trk_t;
    hctig_trk_t s_r, s_nxt;
    always_comb begin
        s_nxt = s_r;
        if (p.query) begin
            s_nxt.fall = 1'b0;
            s_nxt.rise = 1'b0;
        end
        // Set wins over the query clear in the same cycle
        if (p.tick) begin
            s_nxt.last = p.level;
            if (s_r.last && !p.level) s_nxt.fall = 1'b1;
            if (!s_r.last && p.level) s_nxt.rise = 1'b1;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RESET_N) s_r <= '0;
        else s_r <= s_nxt;
    end
    assign p.status = {s_r.rise, s_r.fall, s_r.last};
    a_rise_sets: assert property (@(posedge CLK) disable iff (!RESET_N)
        p.tick && !s_r.last && p.level |=> s_r.rise)
        else $error("rise edge not recorded");
    a_fall_sets: assert property (@(posedge CLK) disable iff (!RESET_N)
        p.tick && s_r.last && !p.level |=> s_r.fall)
        else $error("fall edge not recorded");
endmodule
`default_nettype wire

/* rtl/hctig_pkg.sv */
// Package of constants for the host command text and pin block
package hctig_pkg;
    // ------------------------------------------------------------
    // Packet types and lengths
    // ------------------------------------------------------------
    localparam logic [7:0] TYPE_TXT_WR   = 8'h1f;
    localparam logic [7:0] TYPE_TXT_RD   = 8'h20;
    localparam logic [7:0] TYPE_IF_OPT   = 8'h21;
    localparam logic [7:0] TYPE_PIN      = 8'h22;
    localparam logic [7:0] TYPE_ERR_BASE = 8'hc0;
    localparam logic [7:0] REPLY_BIT     = 8'h40;
    localparam logic [7:0] TXT_WR_MIN    = 8'h03;
    localparam logic [7:0] TXT_WR_MAX    = 8'h16;
    localparam logic [7:0] TXT_RD_LEN    = 8'h03;
    localparam logic [7:0] COLS          = 8'h14;
    localparam logic [7:0] ROWS          = 8'h04;
    localparam int         CELLS         = 80;
    // ------------------------------------------------------------
    // Interface indexes and option bits
    // ------------------------------------------------------------
    localparam logic [7:0] IF_SER = 8'h00;
    localparam logic [7:0] IF_USB = 8'h01;
    localparam logic [7:0] IF_SPI = 8'h02;
    localparam logic [7:0] IF_I2C = 8'h03;
    localparam int OPT_EN   = 0;
    localparam int OPT_INT  = 1;
    localparam int OPT_RPT  = 2;
    localparam int OPT_ELOC = 3;
    localparam int OPT_EANY = 4;
    localparam logic [7:0] OPT_RST   = 8'h07;
    localparam logic [7:0] OPT_USB_F = 8'h01;
    localparam logic [7:0] BAUD_MAX  = 8'h02;
    localparam logic [7:0] SPI_MASK  = 8'h07;
    localparam logic [7:0] I2C_AMAX  = 8'h7f;
    localparam logic [7:0] I2C_SMAX  = 8'h01;
    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    localparam int         NPIN      = 21;
    localparam logic [7:0] PIN_MAX   = 8'h14;
    localparam logic [7:0] ADC0_IDX  = 8'h0d;
    localparam logic [7:0] ADC1_IDX  = 8'h0e;
    localparam logic [7:0] DUTY_MAX  = 8'h64;
    localparam logic [7:0] DRV_BAD   = 8'h06;
    localparam logic [7:0] CFG_RSVD  = 8'hf0;
    localparam logic [7:0] CFG_DFLT  = 8'h02;
    localparam int         CLK_HZ    = 200000000;
    localparam int         PWM_HZ    = 100;
    localparam int         POLL_HZ   = 50;
    localparam int         ADC_HZ    = 11000;
    localparam int PWM_STEP_CYC = CLK_HZ / (PWM_HZ * 100);
    localparam int POLL_CYC     = CLK_HZ / POLL_HZ;
    localparam int ADC_CYC      = CLK_HZ / ADC_HZ;
endpackage
